// ===== hw/pues_pkg.sv
// Purpose: Shared constants for the port unit error status and mask block
// Assumes: 32-bit register port, byte addresses, core clock of 250 MHz
// Notes:   Status and mask bits are sticky; only the power-on reset resets them
package pues_pkg;

	localparam int unsigned REG_ADDR_W     = 12;
	localparam int unsigned REG_DATA_W     = 32;

	// Register byte addresses
	localparam logic [11:0] ADDR_UNIT_STATUS = 12'h140;
	localparam logic [11:0] ADDR_UNIT_MASK   = 12'h144;
	localparam logic [11:0] ADDR_IRQ_MASK    = 12'h150;

	// Unit error status field layout
	localparam int unsigned STATUS_W         = 8;
	localparam int unsigned BIT_RB_HDR_PAR   = 7;
	localparam int unsigned BIT_RB_CTL_PAR   = 6;
	localparam int unsigned BIT_DLLP_TO      = 5;
	localparam int unsigned BIT_SMB_CLTO     = 2;
	localparam int unsigned BIT_SMB_NAK      = 1;
	localparam int unsigned BIT_SMB_ARB      = 0;
	localparam logic [7:0]  STATUS_IMPL      = 8'he7;
	localparam logic [7:0]  STATUS_RESET     = 8'h00;

	// Unit error mask field layout: bits 15:12 held here
	localparam int unsigned MASK_LO          = 12;
	localparam int unsigned MASK_HI          = 15;
	localparam int unsigned MASK_W           = 4;
	localparam int unsigned MBIT_LLP         = 0;
	localparam int unsigned MBIT_CPL_OVF     = 1;
	localparam int unsigned MBIT_NP_OVF      = 2;
	localparam int unsigned MBIT_P_OVF       = 3;
	localparam logic [31:0] UNIT_MASK_RESET  = 32'h0000e000;
	localparam logic [3:0]  MASK_HI_RESET    = UNIT_MASK_RESET[15:12];

	localparam logic [7:0]  IRQ_MASK_RESET   = 8'h00;

	// SMBus clock-low timeout
	localparam int unsigned CLK_FREQ_MHZ       = 250;
	localparam int unsigned SMB_LOW_TIMEOUT_US = 25000;
	localparam int unsigned SMB_LOW_TIMEOUT_CYCLES = SMB_LOW_TIMEOUT_US * CLK_FREQ_MHZ;
	localparam int unsigned SMB_CNT_W          = 24;

endpackage

// ===== hw/pues_smb_low_timer.sv
// Purpose: Detects the SMBus clock line held low longer than the timeout
// Assumes: smb_clk_i is a raw pin, idle high
// Notes:   One pulse per low period; rearms when the line goes high
`timescale 1ns/1ns
`default_nettype none
module pues_smb_low_timer
	import pues_pkg::*;
#(
	parameter int unsigned LOW_CYCLES = pues_pkg::SMB_LOW_TIMEOUT_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic smb_clk_i,
	output var  logic timeout_o
);
	typedef struct packed {
		logic                 sync1;
		logic                 sync2;
		logic [SMB_CNT_W-1:0] cnt;
		logic                 fired;
		logic                 timeout;
	} pues_tmr_type;

	pues_tmr_type s_q;
	pues_tmr_type s_d;

	localparam logic [SMB_CNT_W-1:0] LIMIT = LOW_CYCLES[SMB_CNT_W-1:0];

	always_comb begin
		s_d         = s_q;
		s_d.sync1   = smb_clk_i;
		s_d.sync2   = s_q.sync1;
		s_d.timeout = 1'b0;
		if (s_q.sync2) begin
			s_d.cnt   = '0;
			s_d.fired = 1'b0;
		end else if (!s_q.fired) begin
			if (s_q.cnt == LIMIT) begin
				s_d.timeout = 1'b1;
				s_d.fired   = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q       <= '0;
			s_q.sync1 <= 1'b1;
			s_q.sync2 <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign timeout_o = s_q.timeout;
endmodule
`default_nettype wire

// ===== hw/pcie_unit_error_status_mask.sv
// Purpose: Port unit error status (low bits) and unit error mask (upper bits)
// Assumes: Event inputs are one-cycle pulses on clk_i; smb_clk_i is a raw pin
// Notes:   Register port answers every read one cycle later; no wait states
//
// Function
// - Each status bit resets to zero and clears only on a written one.
// - Status and mask bits survive the ordinary reset; only power-on resets them.
// - A retry buffer header parity error sets bit 7, marks the transaction bad and stops transfers.
// - A retry buffer control parity error sets bit 6, is fatal and stops transfers.
// - Retry buffer header and control parity errors count only while a replay runs.
// - A missing flow-control DLLP sets bit 5, while ACK or NAK timeouts do not.
// - The SMBus clock held low beyond 25 ms sets bit 2.
// - An unexpected SMBus NAK sets bit 1.
// - Lost SMBus arbitration sets bit 0 and is a correctable error.
// - A masked upper-mask event is dropped from unit_report_o; it has no status bit, and err_log_o passes every status event unmasked.
// - The lowest four mask bits do nothing in this device.
// - Mask bits 15, 14 and 13 reset to one, masking the queue overflows.
// - Mask bit 12 gates link-layer protocol error reporting and resets to zero.
`timescale 1ns/1ns
`default_nettype none
module pcie_unit_error_status_mask
	import pues_pkg::*;
#(
	parameter int unsigned SMB_LOW_CYCLES = pues_pkg::SMB_LOW_TIMEOUT_CYCLES
) (
	input  wire logic                            clk_i,
	input  wire logic                            nrst_i,
	input  wire logic                            pwr_on_nrst_i,
	// Register port
	input  wire logic [pues_pkg::REG_ADDR_W-1:0] reg_addr_i,
	input  wire logic [pues_pkg::REG_DATA_W-1:0] reg_wdata_i,
	input  wire logic                            reg_wr_i,
	input  wire logic                            reg_rd_i,
	output var  logic [pues_pkg::REG_DATA_W-1:0] reg_rdata_o,
	// Link layer events
	input  wire logic                            retry_replay_active_i,
	input  wire logic                            rb_hdr_parity_err_i,
	input  wire logic                            rb_ctl_parity_err_i,
	input  wire logic                            fc_dllp_timeout_i,
	input  wire logic                            ack_nak_timeout_i,
	input  wire logic                            link_protocol_err_i,
	input  wire logic                            up_posted_ovf_i,
	input  wire logic                            up_nonposted_ovf_i,
	input  wire logic                            up_cpl_ovf_i,
	// SMBus events
	input  wire logic                            smb_clk_i,
	input  wire logic                            smbus_unexpected_nak_i,
	input  wire logic                            smbus_arbitration_lost_i,
	// Results
	output var  logic                            txn_bad_o,
	output var  logic                            xfer_stop_o,
	output var  logic                            fatal_err_o,
	output var  logic                            corr_err_o,
	output var  logic [pues_pkg::STATUS_W-1:0]   err_log_o,
	output var  logic [pues_pkg::MASK_W-1:0]     unit_report_o,
	output var  logic                            irq_o
);
	// Power-on domain: survives the ordinary reset
	typedef struct packed {
		logic [STATUS_W-1:0] status;
		logic [MASK_W-1:0]   mask_hi;
		logic                xfer_stop;
	} pues_sticky_type;

	// Ordinary reset domain
	typedef struct packed {
		logic [REG_DATA_W-1:0] rdata;
		logic [STATUS_W-1:0]   irq_mask;
		logic                  irq;
		logic                  txn_bad;
		logic                  fatal;
		logic                  corr;
		logic [STATUS_W-1:0]   log;
		logic [MASK_W-1:0]     report;
	} pues_state_type;

	pues_sticky_type sk_q;
	pues_sticky_type sk_d;
	pues_state_type  st_q;
	pues_state_type  st_d;

	logic smb_low_timeout;

	function automatic logic addr_hit(
		input logic [REG_ADDR_W-1:0] addr,
		input logic [REG_ADDR_W-1:0] target
	);
		return addr == target;
	endfunction

	pues_smb_low_timer #(
		.LOW_CYCLES (SMB_LOW_CYCLES)
	) u_smb_low_timer (
		.clk_i     (clk_i),
		.nrst_i    (nrst_i),
		.smb_clk_i (smb_clk_i),
		.timeout_o (smb_low_timeout)
	);

	// Qualified event strobes, one per source except the ACK/NAK timeout, which has none
	logic ev_hdr_par;
	logic ev_ctl_par;
	logic ev_dllp_to;
	logic ev_smb_clto;
	logic ev_smb_nak;
	logic ev_smb_arb;
	logic ev_llp;
	logic ev_cpl_ovf;
	logic ev_np_ovf;
	logic ev_p_ovf;

	// Next-state pieces
	logic [STATUS_W-1:0]   ev;
	logic [STATUS_W-1:0]   clr;
	logic [MASK_W-1:0]     upper_ev;
	logic                  wr_status;
	logic                  wr_mask;
	logic                  wr_irq_mask;
	logic                  rd_status;
	logic                  rd_mask;
	logic                  rd_irq_mask;
	logic                  fatal_ev;
	logic [STATUS_W-1:0]   status_nxt;
	logic [STATUS_W-1:0]   irq_mask_nxt;
	logic [MASK_W-1:0]     mask_nxt;
	logic                  stop_nxt;
	logic [REG_DATA_W-1:0] read_word;
	logic [MASK_W-1:0]     report_nxt;
	logic                  txn_bad_nxt;
	logic                  fatal_nxt;
	logic                  corr_nxt;
	logic [STATUS_W-1:0]   log_nxt;
	logic                  irq_nxt;

	// Sticky bit update; a new event beats a clear in the same cycle
	function automatic logic w1c_bit(
		input logic old_bit,
		input logic clr_bit,
		input logic set_bit
	);
		return (old_bit & ~clr_bit) | set_bit;
	endfunction

	// Mask bit zero lets an event through
	function automatic logic report_bit(
		input logic ev_bit,
		input logic mask_bit
	);
		return ev_bit & ~mask_bit;
	endfunction

	// Status-layout field in a zeroed word
	function automatic logic [REG_DATA_W-1:0] place_status(
		input logic [STATUS_W-1:0] field
	);
		logic [REG_DATA_W-1:0] word;
		word               = '0;
		word[STATUS_W-1:0] = field & STATUS_IMPL;
		return word;
	endfunction

	function automatic logic [REG_DATA_W-1:0] place_mask(
		input logic [MASK_W-1:0] field
	);
		logic [REG_DATA_W-1:0] word;
		word                  = '0;
		word[MASK_HI:MASK_LO] = field;
		return word;
	endfunction

	always_comb begin
		ev_hdr_par  = rb_hdr_parity_err_i & retry_replay_active_i;
		ev_ctl_par  = rb_ctl_parity_err_i & retry_replay_active_i;
		// Flow-control only
		// ACK/NAK timeouts are deliberately not folded in here.
		ev_dllp_to  = fc_dllp_timeout_i;
		ev_smb_clto = smb_low_timeout;
		ev_smb_nak  = smbus_unexpected_nak_i;
		ev_smb_arb  = smbus_arbitration_lost_i;

		// Upper-mask events
		ev_llp      = link_protocol_err_i;
		ev_cpl_ovf  = up_cpl_ovf_i;
		ev_np_ovf   = up_nonposted_ovf_i;
		ev_p_ovf    = up_posted_ovf_i;
	end

	// Status layout; bits 4:3 never set
	always_comb begin
		ev                 = '0;
		ev[BIT_RB_HDR_PAR] = ev_hdr_par;
		ev[BIT_RB_CTL_PAR] = ev_ctl_par;
		ev[BIT_DLLP_TO]    = ev_dllp_to;
		ev[BIT_SMB_CLTO]   = ev_smb_clto;
		ev[BIT_SMB_NAK]    = ev_smb_nak;
		ev[BIT_SMB_ARB]    = ev_smb_arb;

		upper_ev               = '0;
		upper_ev[MBIT_LLP]     = ev_llp;
		upper_ev[MBIT_CPL_OVF] = ev_cpl_ovf;
		upper_ev[MBIT_NP_OVF]  = ev_np_ovf;
		upper_ev[MBIT_P_OVF]   = ev_p_ovf;

		fatal_ev = ev[BIT_RB_HDR_PAR] | ev[BIT_RB_CTL_PAR];
	end

	// Register decode
	always_comb begin
		wr_status   = reg_wr_i & addr_hit(reg_addr_i, ADDR_UNIT_STATUS);
		wr_mask     = reg_wr_i & addr_hit(reg_addr_i, ADDR_UNIT_MASK);
		wr_irq_mask = reg_wr_i & addr_hit(reg_addr_i, ADDR_IRQ_MASK);
		rd_status   = reg_rd_i & addr_hit(reg_addr_i, ADDR_UNIT_STATUS);
		rd_mask     = reg_rd_i & addr_hit(reg_addr_i, ADDR_UNIT_MASK);
		rd_irq_mask = reg_rd_i & addr_hit(reg_addr_i, ADDR_IRQ_MASK);
		clr = wr_status ? (reg_wdata_i[STATUS_W-1:0] & STATUS_IMPL) : '0;
	end

	always_comb begin
		status_nxt = '0;
		for (int i = 0; i < STATUS_W; i++) begin
			if (STATUS_IMPL[i]) begin
				status_nxt[i] = w1c_bit(sk_q.status[i], clr[i], ev[i]);
			end
		end
	end

	always_comb begin
		mask_nxt = sk_q.mask_hi;
		if (wr_mask) begin
			mask_nxt = reg_wdata_i[MASK_HI:MASK_LO];
		end
		irq_mask_nxt = st_q.irq_mask;
		if (wr_irq_mask) begin
			irq_mask_nxt = reg_wdata_i[STATUS_W-1:0] & STATUS_IMPL;
		end
		// Stop while fatal
		// Held until software clears both fatal bits.
		stop_nxt = status_nxt[BIT_RB_HDR_PAR] | status_nxt[BIT_RB_CTL_PAR];
	end

	always_comb begin
		report_nxt[MBIT_LLP]     = report_bit(upper_ev[MBIT_LLP], sk_q.mask_hi[MBIT_LLP]);
		report_nxt[MBIT_CPL_OVF] = report_bit(upper_ev[MBIT_CPL_OVF], sk_q.mask_hi[MBIT_CPL_OVF]);
		report_nxt[MBIT_NP_OVF]  = report_bit(upper_ev[MBIT_NP_OVF], sk_q.mask_hi[MBIT_NP_OVF]);
		report_nxt[MBIT_P_OVF]   = report_bit(upper_ev[MBIT_P_OVF], sk_q.mask_hi[MBIT_P_OVF]);
	end

	// Read data stands one cycle only
	always_comb begin
		read_word = '0;
		if (rd_status) begin
			read_word = place_status(sk_q.status);
		end else if (rd_mask) begin
			read_word = place_mask(sk_q.mask_hi);
		end else if (rd_irq_mask) begin
			read_word = place_status(st_q.irq_mask);
		end
	end

	always_comb begin
		txn_bad_nxt = ev[BIT_RB_HDR_PAR];
		fatal_nxt   = fatal_ev;
		corr_nxt    = ev[BIT_SMB_ARB];
		// Logs see every event; their masks live elsewhere
		log_nxt     = ev;
		// Next values so irq rises with the status bit
		irq_nxt     = |(status_nxt & irq_mask_nxt);
	end

	always_comb begin
		sk_d           = sk_q;
		sk_d.status    = status_nxt;
		sk_d.mask_hi   = mask_nxt;
		sk_d.xfer_stop = stop_nxt;
	end

	always_comb begin
		st_d          = st_q;
		st_d.irq_mask = irq_mask_nxt;
		st_d.rdata    = read_word;
		st_d.txn_bad  = txn_bad_nxt;
		st_d.fatal    = fatal_nxt;
		st_d.corr     = corr_nxt;
		st_d.log      = log_nxt;
		st_d.report   = report_nxt;
		st_d.irq      = irq_nxt;
	end

	always_ff @(posedge clk_i or negedge pwr_on_nrst_i) begin
		if (!pwr_on_nrst_i) begin
			sk_q           <= '0;
			sk_q.status    <= STATUS_RESET;
			sk_q.mask_hi   <= MASK_HI_RESET;
			sk_q.xfer_stop <= 1'b0;
		end else begin
			sk_q <= sk_d;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q          <= '0;
			st_q.irq_mask <= IRQ_MASK_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata_o   = st_q.rdata;
	assign txn_bad_o     = st_q.txn_bad;
	assign xfer_stop_o   = sk_q.xfer_stop;
	assign fatal_err_o   = st_q.fatal;
	assign corr_err_o    = st_q.corr;
	assign err_log_o     = st_q.log;
	assign unit_report_o = st_q.report;
	assign irq_o         = st_q.irq;

endmodule
`default_nettype wire

// ===== verification/pcie_unit_error_status_mask_assertions.sv
// Purpose: Port checks for the unit error status and mask block
// Assumes: Event inputs are one-cycle pulses on clk_i
// Notes:   Idle while either reset is low
`timescale 1ns/1ns
`default_nettype none
module pues_checker #(
	parameter int unsigned SMB_LOW_CYCLES = 20
) (
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        pwr_on_nrst_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        retry_replay_active_i,
	input wire logic        rb_hdr_parity_err_i,
	input wire logic        fc_dllp_timeout_i,
	input wire logic        smbus_unexpected_nak_i,
	input wire logic        smbus_arbitration_lost_i,
	input wire logic        txn_bad_o,
	input wire logic        xfer_stop_o,
	input wire logic        fatal_err_o,
	input wire logic        corr_err_o,
	input wire logic [7:0]  err_log_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i || !pwr_on_nrst_i);
	hdr_par_bad_a: assert property (
		rb_hdr_parity_err_i && retry_replay_active_i |=> txn_bad_o && fatal_err_o && xfer_stop_o)
		else $error("header parity effects missing");
	replay_gate_a: assert property (
		!(rb_hdr_parity_err_i && retry_replay_active_i) |=> !txn_bad_o)
		else $error("bad transaction outside replay");
	fatal_stop_a: assert property (fatal_err_o |-> xfer_stop_o)
		else $error("fatal error without transfer stop");
	dllp_log_a: assert property (err_log_o[5] == $past(fc_dllp_timeout_i))
		else $error("flow-control timeout log wrong");
	nak_log_a: assert property (smbus_unexpected_nak_i |=> err_log_o[1])
		else $error("unexpected nak not logged");
	arb_corr_a: assert property (
		corr_err_o == $past(smbus_arbitration_lost_i) && err_log_o[0] == corr_err_o)
		else $error("arbitration loss not correctable");
	rsvd_log_a: assert property (err_log_o[4:3] == 2'h0)
		else $error("reserved log bits set");
	mask_rsvd_a: assert property (
		reg_rd_i && reg_addr_i == 12'h144 |=> reg_rdata_o[31:16] == 16'h0 && reg_rdata_o[11:0] == 12'h0)
		else $error("reserved mask bits read nonzero");
	cover property (rb_hdr_parity_err_i && retry_replay_active_i);
	cover property (smbus_unexpected_nak_i);
	cover property (reg_rd_i && reg_addr_i == 12'h144);
endmodule
bind pcie_unit_error_status_mask pues_checker #(.SMB_LOW_CYCLES(SMB_LOW_CYCLES)) chk_i (
	.clk_i, .nrst_i, .pwr_on_nrst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o,
	.retry_replay_active_i, .rb_hdr_parity_err_i, .fc_dllp_timeout_i,
	.smbus_unexpected_nak_i, .smbus_arbitration_lost_i, .txn_bad_o, .xfer_stop_o,
	.fatal_err_o, .corr_err_o, .err_log_o);
`default_nettype wire

// ===== verification/pcie_unit_error_status_mask_tb.sv
// Purpose: Self-checking bench for the unit error status and mask block
// Assumes: Short SMBus low timeout for simulation
// Notes:   Events packed in one vector; report bits share log layout above bit 7
`timescale 1ns/1ns
`default_nettype none
module pcie_unit_error_status_mask_tb;
	import pues_pkg::*;
	localparam int unsigned LOW = 20;
	logic        clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        pon_n = 1'b0;
	logic [11:0] addr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        replay = 1'b0;
	logic        smb_clk = 1'b1;
	logic [11:0] ev = 12'h0;
	logic [31:0] rdata;
	logic [7:0]  log_v;
	logic [3:0]  rep;
	logic        txn_bad, xfer_stop, fatal, corr, irq;
	int          error_cnt = 0;
	int          checks_done = 0;
	pcie_unit_error_status_mask #(.SMB_LOW_CYCLES(LOW)) uut (
		.clk_i, .nrst_i, .pwr_on_nrst_i(pon_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .retry_replay_active_i(replay),
		.rb_hdr_parity_err_i(ev[7]), .rb_ctl_parity_err_i(ev[6]), .fc_dllp_timeout_i(ev[5]),
		.ack_nak_timeout_i(ev[4]), .link_protocol_err_i(ev[8]), .up_cpl_ovf_i(ev[9]),
		.up_nonposted_ovf_i(ev[10]), .up_posted_ovf_i(ev[11]), .smb_clk_i(smb_clk),
		.smbus_unexpected_nak_i(ev[1]), .smbus_arbitration_lost_i(ev[0]), .txn_bad_o(txn_bad),
		.xfer_stop_o(xfer_stop), .fatal_err_o(fatal), .corr_err_o(corr), .err_log_o(log_v),
		.unit_report_o(rep), .irq_o(irq));
	always #2 clk_i = ~clk_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		@(negedge clk_i);
		chk(rdata, e);
	endtask
	// Pulse events, then judge log and report one cycle after the pulse
	task automatic ev_chk(input logic [11:0] v, input logic [11:0] e);
		@(posedge clk_i);
		ev <= v;
		@(posedge clk_i);
		ev <= 12'h0;
		@(negedge clk_i);
		chk({20'h0, rep, log_v}, {20'h0, e});
	endtask
	// Irq follows the write edge itself
	task automatic irq_chk(input logic e);
		@(negedge clk_i);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	task automatic t_mask;
		rd_chk(ADDR_UNIT_MASK, 32'h0000e000);
		rd_chk(12'h7fc, 32'h0);
		ev_chk(12'h100, 12'h100);
		ev_chk(12'he00, 12'h000);
		wr_reg(ADDR_UNIT_MASK, 32'hffffffff);
		rd_chk(ADDR_UNIT_MASK, 32'h0000f000);
		ev_chk(12'h100, 12'h000);
		wr_reg(ADDR_UNIT_MASK, 32'h0);
		ev_chk(12'he00, 12'he00);
	endtask
	task automatic t_events;
		rd_chk(ADDR_UNIT_STATUS, 32'h0);
		ev_chk(12'h020, 12'h020);
		ev_chk(12'h010, 12'h000);
		ev_chk(12'h002, 12'h002);
		ev_chk(12'h001, 12'h001);
		chk({31'h0, corr}, 32'h1);
		ev_chk(12'h0c0, 12'h000);
		replay <= 1'b1;
		ev_chk(12'h080, 12'h080);
		chk({30'h0, txn_bad, fatal}, 32'h3);
		ev_chk(12'h040, 12'h040);
		replay <= 1'b0;
		chk({31'h0, xfer_stop}, 32'h1);
		rd_chk(ADDR_UNIT_STATUS, 32'he3);
	endtask
	task automatic t_clear;
		wr_reg(ADDR_UNIT_STATUS, 32'hffffff18);
		rd_chk(ADDR_UNIT_STATUS, 32'he3);
		wr_reg(ADDR_UNIT_STATUS, 32'h80);
		rd_chk(ADDR_UNIT_STATUS, 32'h63);
		chk({31'h0, xfer_stop}, 32'h1);
		wr_reg(ADDR_UNIT_STATUS, 32'h40);
		irq_chk(1'b0);
		chk({31'h0, xfer_stop}, 32'h0);
		wr_reg(ADDR_IRQ_MASK, 32'h02);
		irq_chk(1'b1);
		wr_reg(ADDR_IRQ_MASK, 32'h0);
		irq_chk(1'b0);
		wr_reg(ADDR_IRQ_MASK, 32'h02);
		wr_reg(ADDR_UNIT_STATUS, 32'h02);
		irq_chk(1'b0);
	endtask
	task automatic t_smb;
		@(posedge clk_i);
		smb_clk <= 1'b0;
		repeat (LOW - 4) @(posedge clk_i);
		rd_chk(ADDR_UNIT_STATUS, 32'h21);
		repeat (12) @(posedge clk_i);
		smb_clk <= 1'b1;
		rd_chk(ADDR_UNIT_STATUS, 32'h25);
	endtask
	task automatic t_sticky;
		wr_reg(ADDR_UNIT_MASK, 32'h2000);
		@(posedge clk_i);
		nrst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		rd_chk(ADDR_UNIT_STATUS, 32'h25);
		rd_chk(ADDR_UNIT_MASK, 32'h2000);
		rd_chk(ADDR_IRQ_MASK, 32'h0);
		@(posedge clk_i);
		pon_n <= 1'b0;
		repeat (2) @(posedge clk_i);
		pon_n <= 1'b1;
		rd_chk(ADDR_UNIT_STATUS, 32'h0);
		rd_chk(ADDR_UNIT_MASK, 32'he000);
	endtask
	task automatic tally_and_finish;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
		pon_n <= 1'b1;
		t_mask;
		t_events;
		t_clear;
		t_smb;
		t_sticky;
		tally_and_finish;
	end
	initial begin
		#20000;
		error_cnt++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
